// ---- i2cmc_top.sv ----
// Contract
// - The controller only masters the bus, starting every transfer and never answering as slave.
// - It shares the bus with other masters, waiting while another holds it.
// - It generates the serial clock at 400 kHz or 1 MHz as selected.
// - It waits while a slow slave holds the clock line low.
// - It can fetch a boot image from an EEPROM on the bus when that boot option is chosen.
// - Strap pattern F1F boots from EEPROM with USB fallback, and 1FF from EEPROM only.
// - The sensor channel runs at 100 kHz or 400 kHz with 7-bit addressing.
// - Bus signalling follows revision 3 of the two-wire bus standard.
`timescale 1ns/1ps
`default_nettype none
module i2cmc_top (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic LINK_CLK,
    input wire logic CMD_VALID,
    output logic CMD_READY,
    input wire i2cmc_pkg::i2cmc_cmd_t CMD,
    input wire i2cmc_pkg::i2cmc_speed_t SPEED,
    output logic RSP_VALID,
    output i2cmc_pkg::i2cmc_rsp_t RSP,
    output logic BUSY,
    output logic NACK_ERR,
    output logic ARB_LOST,
    input wire logic ERR_CLEAR,
    input wire logic SCL_I,
    output logic SCL_O,
    output logic SCL_OE_N,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_N,
    input wire logic [2:0] BOOT_SOURCE_PINS,
    input wire logic [2:0] BOOT_SOURCE_FLOAT,
    input wire logic BOOT_FAIL,
    output logic BOOT_FROM_EEPROM,
    output logic USB_BOOT_EN
);
    import i2cmc_pkg::*;

    typedef enum logic [3:0] {
        S_IDLE, S_RESTART, S_RSCL, S_START, S_LOW, S_HIGH,
        S_STOP1, S_STOP2, S_STOP3, S_DONE
    } i2cmc_state_t;

    // ---------------- reference clock side ----------------
    logic f_valid;
    logic f_ready;
    i2cmc_xfer_t f_data;
    i2cmc_xfer_t push_data;
    logic pend_reg;
    logic req_tgl_reg;
    i2cmc_xfer_t hold_reg;
    logic ack_m_reg;
    logic ack_s_reg;
    logic ack_d_reg;
    logic rsp_valid_reg;
    i2cmc_rsp_t rsp_out_reg;
    logic nack_err_reg;
    logic arb_lost_reg;
    logic ack_tgl_reg;
    i2cmc_rsp_t rsp_reg;

    assign push_data = '{speed: SPEED, cmd: CMD};

    // commands queue here so firmware can post a whole transfer at once
    i2cmc_fifo #(
        .WIDTH(XFER_W),
        .DEPTH(FIFO_DEPTH)
    ) u_cmd_fifo (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .in_valid(CMD_VALID),
        .in_ready(CMD_READY),
        .in_data(push_data),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    // one byte in flight across the crossing; fifo stalls meanwhile
    wire take = f_valid && !pend_reg;
    wire rsp_evt = ack_s_reg ^ ack_d_reg;
    wire nack_next = (rsp_evt && rsp_reg.nack) || (nack_err_reg && !ERR_CLEAR);
    wire arb_next = (rsp_evt && rsp_reg.arb_lost) || (arb_lost_reg && !ERR_CLEAR);
    assign f_ready = !pend_reg;

    // request toggle with the held word, answer toggle back
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            pend_reg <= 1'b0;
            req_tgl_reg <= 1'b0;
            hold_reg <= '0;
        end
        else
        begin
            if (take)
            begin
                hold_reg <= f_data;
                req_tgl_reg <= ~req_tgl_reg;
            end
            pend_reg <= take || (pend_reg && !rsp_evt);
        end
    end

    // answer toggle synchroniser and sticky error flags, set beats clear
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            ack_m_reg <= 1'b0;
            ack_s_reg <= 1'b0;
            ack_d_reg <= 1'b0;
            rsp_valid_reg <= 1'b0;
            rsp_out_reg <= '0;
            nack_err_reg <= 1'b0;
            arb_lost_reg <= 1'b0;
        end
        else
        begin
            ack_m_reg <= ack_tgl_reg;
            ack_s_reg <= ack_m_reg;
            ack_d_reg <= ack_s_reg;
            rsp_valid_reg <= rsp_evt;
            if (rsp_evt)
                rsp_out_reg <= rsp_reg;
            nack_err_reg <= nack_next;
            arb_lost_reg <= arb_next;
        end
    end

    assign RSP_VALID = rsp_valid_reg;
    assign RSP = rsp_out_reg;
    assign NACK_ERR = nack_err_reg;
    assign ARB_LOST = arb_lost_reg;
    assign BUSY = pend_reg || f_valid;

    // ---------------- boot straps ----------------
    logic [5:0] strap_m_reg;
    logic [5:0] strap_s_reg;
    logic [1:0] settle_reg;
    logic boot_eeprom_reg;
    logic boot_fb_reg;
    logic usb_en_reg;

    wire [2:0] st_lvl = strap_s_reg[2:0];
    wire [2:0] st_flt = strap_s_reg[5:3];
    wire is_f1f = (st_flt == BOOT_FB_FLOAT) && ((st_lvl & ~st_flt) == BOOT_FB_LEVEL);
    wire is_1ff = (st_flt == BOOT_ONLY_FLOAT) && ((st_lvl & ~st_flt) == BOOT_ONLY_LEVEL);
    wire strap_take = (settle_reg == STRAP_SETTLE - 2'h1);

    // straps are caught only after the synchroniser has filled
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            strap_m_reg <= '0;
            strap_s_reg <= '0;
            settle_reg <= '0;
            boot_eeprom_reg <= 1'b0;
            boot_fb_reg <= 1'b0;
            usb_en_reg <= 1'b0;
        end
        else
        begin
            strap_m_reg <= {BOOT_SOURCE_FLOAT, BOOT_SOURCE_PINS};
            strap_s_reg <= strap_m_reg;
            if (settle_reg != STRAP_SETTLE)
                settle_reg <= settle_reg + 2'h1;
            if (strap_take)
            begin
                boot_eeprom_reg <= is_f1f || is_1ff;
                boot_fb_reg <= is_f1f;
            end
            if (settle_reg == STRAP_SETTLE)
                usb_en_reg <= !boot_eeprom_reg || (boot_fb_reg && BOOT_FAIL);
        end
    end

    // boot loader drives the same command port while this is high
    assign BOOT_FROM_EEPROM = boot_eeprom_reg;
    assign USB_BOOT_EN = usb_en_reg;

    // ---------------- link clock side ----------------
    logic lrst_m_reg;
    logic lrst_s_reg;
    logic req_m_reg;
    logic req_s_reg;
    logic scl_m_reg;
    logic scl_s_reg;
    logic sda_m_reg;
    logic sda_s_reg;
    logic sda_d_reg;
    logic seen_reg, seen_next;
    logic bus_busy_reg;
    i2cmc_state_t state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [3:0] bit_reg, bit_next;
    logic [7:0] shift_reg, shift_next;
    i2cmc_xfer_t cur_reg, cur_next;
    logic own_reg, own_next;
    logic scl_drv_reg, scl_drv_next;
    logic sda_drv_reg, sda_drv_next;
    logic ack_tgl_next;
    i2cmc_rsp_t rsp_next;
    wire link_rst_n = lrst_s_reg;

    // local reset follows the reference reset into this domain
    always_ff @(posedge LINK_CLK)
    begin
        lrst_m_reg <= RST_N;
        lrst_s_reg <= lrst_m_reg;
    end

    // start/stop seen on the wire, by us or by another master
    wire start_seen = scl_s_reg && sda_d_reg && !sda_s_reg;
    wire stop_seen = scl_s_reg && !sda_d_reg && sda_s_reg;
    wire bus_busy_next = start_seen || (bus_busy_reg && !stop_seen);
    wire new_cmd = req_s_reg ^ seen_reg;
    wire [CNT_W-1:0] half_cyc = half_of(cur_reg.speed);
    wire half_done = (cnt_reg == half_cyc - 1'b1);
    wire ack_slot = (bit_reg == ACK_SLOT);
    wire arb_hit = (state_reg == S_HIGH) && scl_s_reg && !ack_slot && !cur_reg.cmd.rd
        && !sda_drv_reg && !sda_s_reg;
    wire nack_hit = (state_reg == S_HIGH) && scl_s_reg && half_done && ack_slot
        && !cur_reg.cmd.rd && sda_s_reg;
    wire need_start = hold_reg.cmd.start || !own_reg;

    // pin and request synchronisers, bus start/stop watcher
    always_ff @(posedge LINK_CLK)
    begin
        if (!link_rst_n)
        begin
            {req_m_reg, req_s_reg} <= 2'h0;
            {scl_m_reg, scl_s_reg} <= 2'h3;
            {sda_m_reg, sda_s_reg, sda_d_reg} <= 3'h7;
            bus_busy_reg <= 1'b0;
        end
        else
        begin
            req_m_reg <= req_tgl_reg;
            req_s_reg <= req_m_reg;
            scl_m_reg <= SCL_I;
            scl_s_reg <= scl_m_reg;
            sda_m_reg <= SDA_I;
            sda_s_reg <= sda_m_reg;
            sda_d_reg <= sda_s_reg;
            bus_busy_reg <= bus_busy_next;
        end
    end

    // half period by speed; 100k serves the sensor channel
    function automatic logic [CNT_W-1:0] half_of(input i2cmc_speed_t spd);
        unique case (spd)
            I2CMC_SPD_100K: half_of = HALF_100K_CYC;
            I2CMC_SPD_400K: half_of = HALF_400K_CYC;
            I2CMC_SPD_1M: half_of = HALF_1M_CYC;
            default: half_of = HALF_100K_CYC;
        endcase
    endfunction : half_of

    // level to pull onto data during a low phase; 1 means pull low
    function automatic logic pull_for(input logic [3:0] b, input i2cmc_cmd_t c,
        input logic [7:0] sh);
        if (b == ACK_SLOT)
            pull_for = c.rd && c.ack_out;
        else
            pull_for = !c.rd && !sh[7];
    endfunction : pull_for

    // byte engine; the held word is stable while our toggle is pending
    always_comb
    begin
        state_next = state_reg;
        cnt_next = '0;
        bit_next = bit_reg;
        shift_next = shift_reg;
        cur_next = cur_reg;
        own_next = own_reg;
        scl_drv_next = scl_drv_reg;
        sda_drv_next = sda_drv_reg;
        rsp_next = rsp_reg;
        ack_tgl_next = ack_tgl_reg;
        seen_next = seen_reg;
        unique case (state_reg)
            S_IDLE:
            begin
                // never waits on an address from outside: master only
                if (new_cmd && !(need_start && !own_reg && bus_busy_reg))
                begin
                    cur_next = hold_reg;
                    seen_next = req_s_reg;
                    bit_next = '0;
                    shift_next = hold_reg.cmd.wdata;
                    rsp_next = '0;
                    if (need_start && own_reg)
                        state_next = S_RESTART;
                    else if (need_start)
                    begin
                        state_next = S_START;
                        sda_drv_next = 1'b1;
                    end
                    else
                        state_next = S_LOW;
                end
            end
            S_RESTART:
            begin
                sda_drv_next = 1'b0;
                cnt_next = half_done ? '0 : cnt_reg + 1'b1;
                if (half_done)
                begin
                    state_next = S_RSCL;
                    scl_drv_next = 1'b0;
                end
            end
            S_RSCL, S_STOP2:
            begin
                // slave may hold the clock low; the count waits
                if (!scl_s_reg)
                    cnt_next = cnt_reg;
                else
                begin
                    cnt_next = half_done ? '0 : cnt_reg + 1'b1;
                    if (half_done)
                    begin
                        state_next = (state_reg == S_RSCL) ? S_START : S_STOP3;
                        sda_drv_next = (state_reg == S_RSCL);
                    end
                end
            end
            S_START:
            begin
                cnt_next = half_done ? '0 : cnt_reg + 1'b1;
                if (half_done)
                begin
                    state_next = S_LOW;
                    scl_drv_next = 1'b1;
                    own_next = 1'b1;
                end
            end
            S_LOW:
            begin
                // data moves one link cycle after the clock falls, for hold
                if (cnt_reg == '0)
                    sda_drv_next = pull_for(bit_reg, cur_reg.cmd, shift_reg);
                cnt_next = half_done ? '0 : cnt_reg + 1'b1;
                if (half_done)
                begin
                    state_next = S_HIGH;
                    scl_drv_next = 1'b0;
                end
            end
            S_HIGH:
            begin
                if (!scl_s_reg)
                    cnt_next = cnt_reg;
                else if (arb_hit)
                begin
                    // someone pulled data low while we let it float
                    scl_drv_next = 1'b0;
                    sda_drv_next = 1'b0;
                    own_next = 1'b0;
                    rsp_next.arb_lost = 1'b1;
                    state_next = S_DONE;
                end
                else
                begin
                    cnt_next = half_done ? '0 : cnt_reg + 1'b1;
                    if (half_done && !ack_slot)
                    begin
                        shift_next = {shift_reg[6:0], sda_s_reg};
                        bit_next = bit_reg + 4'h1;
                        state_next = S_LOW;
                        scl_drv_next = 1'b1;
                    end
                    else if (half_done)
                    begin
                        rsp_next.ack_in = !sda_s_reg;
                        rsp_next.nack = nack_hit;
                        scl_drv_next = 1'b1;
                        state_next = (nack_hit || cur_reg.cmd.stop) ? S_STOP1 : S_DONE;
                    end
                end
            end
            S_STOP1:
            begin
                if (cnt_reg == '0)
                    sda_drv_next = 1'b1;
                cnt_next = half_done ? '0 : cnt_reg + 1'b1;
                if (half_done)
                begin
                    state_next = S_STOP2;
                    scl_drv_next = 1'b0;
                end
            end
            S_STOP3:
            begin
                cnt_next = half_done ? '0 : cnt_reg + 1'b1;
                if (half_done)
                begin
                    state_next = S_DONE;
                    own_next = 1'b0;
                end
            end
            S_DONE:
            begin
                rsp_next.rdata = shift_reg;
                ack_tgl_next = ~ack_tgl_reg;
                state_next = S_IDLE;
            end
            default: state_next = S_IDLE;
        endcase
    end

    // link state registers
    always_ff @(posedge LINK_CLK)
    begin
        if (!link_rst_n)
        begin
            state_reg <= S_IDLE;
            cnt_reg <= '0;
            bit_reg <= '0;
            shift_reg <= '0;
            cur_reg <= '0;
            own_reg <= 1'b0;
            scl_drv_reg <= 1'b0;
            sda_drv_reg <= 1'b0;
            rsp_reg <= '0;
            ack_tgl_reg <= 1'b0;
            seen_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            bit_reg <= bit_next;
            shift_reg <= shift_next;
            cur_reg <= cur_next;
            own_reg <= own_next;
            scl_drv_reg <= scl_drv_next;
            sda_drv_reg <= sda_drv_next;
            rsp_reg <= rsp_next;
            ack_tgl_reg <= ack_tgl_next;
            seen_reg <= seen_next;
        end
    end

    // open drain: only ever pull low, enable active low
    assign SCL_O = 1'b0;
    assign SDA_O = 1'b0;
    assign SCL_OE_N = !scl_drv_reg;
    assign SDA_OE_N = !sda_drv_reg;

    property p_master_only;
        @(posedge LINK_CLK) disable iff (!link_rst_n)
        (state_reg == S_IDLE && !own_reg) |-> SCL_OE_N && SDA_OE_N;
    endproperty
    a_master_only: assert property (p_master_only)
        else $error("bus driven while idle and not owner");

    property p_wait_other;
        @(posedge LINK_CLK) disable iff (!link_rst_n)
        (state_reg == S_IDLE && new_cmd && !own_reg && bus_busy_reg)
        |=> state_reg == S_IDLE;
    endproperty
    a_wait_other: assert property (p_wait_other)
        else $error("start issued while another master holds the bus");

    property p_low_len;
        @(posedge LINK_CLK) disable iff (!link_rst_n)
        $rose(state_reg == S_LOW) |-> (state_reg == S_LOW)[*3] ##1 !SCL_OE_N;
    endproperty
    a_low_len: assert property (p_low_len)
        else $error("clock low phase too short");

    property p_stretch;
        @(posedge LINK_CLK) disable iff (!link_rst_n)
        (state_reg == S_HIGH && !scl_s_reg) |=> state_reg == S_HIGH
        && cnt_reg == $past(cnt_reg);
    endproperty
    a_stretch: assert property (p_stretch)
        else $error("clock stretch not honoured");

    property p_ack_release;
        @(posedge LINK_CLK) disable iff (!link_rst_n)
        (state_reg == S_HIGH && ack_slot && !cur_reg.cmd.rd) |-> SDA_OE_N;
    endproperty
    a_ack_release: assert property (p_ack_release)
        else $error("data held during slave acknowledge");

    property p_arb_release;
        @(posedge LINK_CLK) disable iff (!link_rst_n)
        arb_hit |=> state_reg == S_DONE && SCL_OE_N && SDA_OE_N && !own_reg
        ##1 ack_tgl_reg != $past(ack_tgl_reg);
    endproperty
    a_arb_release: assert property (p_arb_release)
        else $error("bus not released after lost arbitration");

    property p_nack_stop;
        @(posedge LINK_CLK) disable iff (!link_rst_n)
        nack_hit |=> state_reg == S_STOP1 ##1 !SDA_OE_N;
    endproperty
    a_nack_stop: assert property (p_nack_stop)
        else $error("no stop after missing acknowledge");

    property p_nack_flag;
        @(posedge REF_CLK) disable iff (!RST_N)
        (rsp_evt && rsp_reg.nack) |=> NACK_ERR && RSP_VALID && RSP.nack;
    endproperty
    a_nack_flag: assert property (p_nack_flag)
        else $error("missing acknowledge not reported");

    property p_boot_mode;
        @(posedge REF_CLK) disable iff (!RST_N)
        strap_take |=> BOOT_FROM_EEPROM == $past(is_f1f || is_1ff)
        ##1 USB_BOOT_EN == (!BOOT_FROM_EEPROM || (boot_fb_reg && $past(BOOT_FAIL)));
    endproperty
    a_boot_mode: assert property (p_boot_mode)
        else $error("boot source does not follow straps");

endmodule : i2cmc_top
`default_nettype wire

// ---- i2cmc_pkg.sv ----
package i2cmc_pkg;

    // clock periods of the two domains
    localparam int REF_CLK_NS = 20;
    localparam int LINK_CLK_NS = 80;

    // least half periods of the serial clock, per speed grade
    localparam int HALF_100K_NS = 5000;
    localparam int HALF_400K_NS = 1250;
    localparam int HALF_1M_NS = 500;

    // half-period counter
    localparam int CNT_W = 7;
    localparam logic [CNT_W-1:0] HALF_100K_CYC =
        CNT_W'((HALF_100K_NS + LINK_CLK_NS - 1) / LINK_CLK_NS);
    localparam logic [CNT_W-1:0] HALF_400K_CYC =
        CNT_W'((HALF_400K_NS + LINK_CLK_NS - 1) / LINK_CLK_NS);
    localparam logic [CNT_W-1:0] HALF_1M_CYC =
        CNT_W'((HALF_1M_NS + LINK_CLK_NS - 1) / LINK_CLK_NS);

    // bit slots per byte: eight data bits and the acknowledge slot
    localparam logic [3:0] ACK_SLOT = 4'h8;

    // command buffer
    localparam int FIFO_DEPTH = 8;

    // boot straps: float mask and level of the non-floating pins
    localparam logic [2:0] BOOT_FB_FLOAT = 3'h5;
    localparam logic [2:0] BOOT_FB_LEVEL = 3'h2;
    localparam logic [2:0] BOOT_ONLY_FLOAT = 3'h3;
    localparam logic [2:0] BOOT_ONLY_LEVEL = 3'h4;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    typedef enum logic [1:0] {
        I2CMC_SPD_100K,
        I2CMC_SPD_400K,
        I2CMC_SPD_1M
    } i2cmc_speed_t;

    // one byte of a transfer
    typedef struct packed {
        logic start;
        logic stop;
        logic rd;
        logic ack_out;
        logic [7:0] wdata;
    } i2cmc_cmd_t;

    typedef struct packed {
        i2cmc_speed_t speed;
        i2cmc_cmd_t cmd;
    } i2cmc_xfer_t;

    typedef struct packed {
        logic [7:0] rdata;
        logic ack_in;
        logic arb_lost;
        logic nack;
    } i2cmc_rsp_t;

    localparam int XFER_W = $bits(i2cmc_xfer_t);

endpackage : i2cmc_pkg

// ---- i2cmc_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module i2cmc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // honest flags straight from the fill count
    assign in_ready = (cnt_reg != FULL_CNT);
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem_reg[rd_reg];

    // pointer wrap at any depth, not only powers of two
    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == LAST_IDX) ? '0 : p + 1'b1;
    endfunction : bump

    // storage
    always_ff @(posedge clk)
    begin
        if (push)
            mem_reg[wr_reg] <= in_data;
    end

    // pointers and count
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            if (push)
                wr_reg <= bump(wr_reg);
            if (pop)
                rd_reg <= bump(rd_reg);
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    property p_full_refuses;
        @(posedge clk) disable iff (!rst_n)
        (cnt_reg == FULL_CNT) |-> !in_ready ##0 out_valid;
    endproperty
    a_full_refuses: assert property (p_full_refuses)
        else $error("fifo full but still ready");

endmodule : i2cmc_fifo
`default_nettype wire

// ---- i2cmc_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
// behavioural slave: acks its address and written bytes, serves rd_byte on reads
module i2cmc_slave #(
    parameter logic [6:0] ADDR = 7'h50 // kept clear of the reserved 0000111x block
) (
    input wire logic scl,
    input wire logic sda,
    input wire logic [7:0] rd_byte,
    output logic scl_oe_n,
    output logic sda_oe_n
);
    logic [3:0] cnt = 4'h0;
    logic [7:0] sh = 8'h00;
    logic act = 1'b0;
    logic hdr = 1'b0;
    logic rd = 1'b0;
    initial scl_oe_n = 1'b1;
    initial sda_oe_n = 1'b1;
    // start and stop: sda moving while scl is high
    // the clock fall that ends a start wraps the count to 0 before the first bit
    always @(negedge sda) if (scl) {act, hdr, rd, cnt} = {3'b110, 4'hf};
    always @(posedge sda) if (scl) act = 1'b0;
    always @(posedge scl) if (act) sh = {sh[6:0], sda};
    // all slave drive changes only while scl is low, never mimicking start or stop
    always @(negedge scl)
    if (act)
    begin
        sda_oe_n = 1'b1;
        if (cnt == 4'h7)
        begin
            sda_oe_n = !(hdr ? sh[7:1] == ADDR : !rd); // answers only when addressed
            if (hdr)
                {rd, act} = {sh[0], sh[7:1] == ADDR};
        end
        else if (cnt == 4'h8 && rd && !hdr && sh[0])
            act = 1'b0; // master declined the byte: let go for its stop
        if (act && rd && (cnt < 4'h7 || cnt == 4'h8))
            sda_oe_n = rd_byte[cnt == 4'h8 ? 7 : 6 - cnt];
        if (act && cnt == 4'h8)
        begin
            hdr = 1'b0;
            scl_oe_n = 1'b0; // slow device: stretch after every byte except a read the master declines
            #2000 scl_oe_n = 1'b1;
        end
        cnt = (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
    end
endmodule : i2cmc_slave
`default_nettype wire

// ---- i2c_master_controller_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module i2c_master_controller_tb;
    import i2cmc_pkg::*;
    logic ref_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_v = 1'b0;
    logic clr = 1'b0;
    logic fail = 1'b0;
    logic [2:0] pins = 3'h0;
    logic [2:0] flt = 3'h0;
    i2cmc_cmd_t cmd = '0;
    i2cmc_speed_t spd = I2CMC_SPD_100K;
    i2cmc_rsp_t rsp;
    wire logic cmd_rdy, rsp_v, busy, nack_f, arb_f, m_scl, m_sda, s_scl, s_sda, boot_e, usb_e;
    wire logic scl = m_scl & s_scl; // pulled up unless a party pulls low
    wire logic sda = m_sda & s_sda;
    int err_count = 0;
    int n_checks = 0;
    realtime t_last = 0.0;
    realtime min_p = 1.0e9;
    always #10 ref_clk = ~ref_clk;
    // link clock offset so its edges never line up with the reference clock
    initial #7 forever #40 link_clk = ~link_clk;
    i2cmc_top dut (.REF_CLK(ref_clk), .RST_N(rst_n), .LINK_CLK(link_clk), .CMD_VALID(cmd_v),
        .CMD_READY(cmd_rdy), .CMD(cmd), .SPEED(spd), .RSP_VALID(rsp_v), .RSP(rsp), .BUSY(busy),
        .NACK_ERR(nack_f), .ARB_LOST(arb_f), .ERR_CLEAR(clr), .SCL_I(scl), .SCL_O(),
        .SCL_OE_N(m_scl), .SDA_I(sda), .SDA_O(), .SDA_OE_N(m_sda), .BOOT_SOURCE_PINS(pins),
        .BOOT_SOURCE_FLOAT(flt), .BOOT_FAIL(fail), .BOOT_FROM_EEPROM(boot_e), .USB_BOOT_EN(usb_e));
    i2cmc_slave slv (.scl(scl), .sda(sda), .rd_byte(8'h96), .scl_oe_n(s_scl), .sda_oe_n(s_sda));
    // shortest scl period on the wire since the last rate check
    always @(posedge scl)
    begin
        if (t_last > 0.0 && $realtime - t_last < min_p)
            min_p = $realtime - t_last;
        t_last = $realtime;
    end
    task automatic chk(input string nm, input logic [10:0] exp, input logic [10:0] got);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic rate_ok(input realtime lim);
        chk("scl_period", 11'h1, {10'h0, min_p >= lim});
        min_p = 1.0e9;
        t_last = 0.0;
    endtask : rate_ok
    // push one command, wait for its answer and compare it
    task automatic xfer(input i2cmc_cmd_t c, input i2cmc_speed_t s, input logic [10:0] exp);
        @(posedge ref_clk);
        cmd <= c;
        spd <= s;
        cmd_v <= 1'b1;
        do @(negedge ref_clk); while (cmd_rdy !== 1'b1);
        @(posedge ref_clk);
        cmd_v <= 1'b0;
        for (int n = 0; n < 12000 && rsp_v !== 1'b1; n++) @(negedge ref_clk);
        chk("rsp", exp, rsp);
    endtask : xfer
    task automatic boot(input logic [2:0] f, input logic [2:0] p, input logic [1:0] exp);
        @(posedge ref_clk);
        {flt, pins, fail, rst_n} <= {f, p, 2'b10};
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (8) @(negedge ref_clk);
        chk("boot", {9'h0, exp}, {9'h0, boot_e, usb_e});
    endtask : boot
    task automatic t_write;
        xfer({4'b1000, 8'ha0}, I2CMC_SPD_400K, {8'ha0, 2'b10, 1'b0});
        xfer({4'b0000, 8'h3c}, I2CMC_SPD_400K, {8'h3c, 2'b10, 1'b0});
        xfer({4'b0100, 8'hc5}, I2CMC_SPD_400K, {8'hc5, 2'b10, 1'b0});
        rate_ok(2500.0);
    endtask : t_write
    task automatic t_read;
        xfer({4'b1000, 8'ha1}, I2CMC_SPD_1M, {8'ha1, 2'b10, 1'b0});
        xfer({4'b0011, 8'h00}, I2CMC_SPD_1M, {8'h96, 2'b10, 1'b0});
        xfer({4'b0110, 8'h00}, I2CMC_SPD_1M, {8'h96, 2'b00, 1'b0});
        rate_ok(1000.0);
    endtask : t_read
    // nobody answers this address; stop and sticky flag must follow
    task automatic t_nack;
        xfer({4'b1100, 8'h20}, I2CMC_SPD_100K, {8'h20, 2'b00, 1'b1});
        repeat (4) @(negedge ref_clk);
        chk("idle", 11'h7, {8'h0, scl, sda, !busy});
        chk("nack_err", 11'h2, {9'h0, nack_f, arb_f});
        @(posedge ref_clk);
        clr <= 1'b1;
        @(posedge ref_clk);
        clr <= 1'b0;
        repeat (2) @(negedge ref_clk);
        chk("nack_clr", 11'h0, {10'h0, nack_f});
        rate_ok(10000.0);
    endtask : t_nack
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done
    initial
    begin
        boot(3'h5, 3'h2, 2'b11);
        boot(3'h4, 3'h3, 2'b01);
        boot(3'h3, 3'h4, 2'b10);
        t_write();
        t_read();
        t_nack();
        test_done();
    end
    // watchdog well past the slowest expected run
    initial
    begin
        #1.5ms;
        err_count++;
        test_done();
    end
endmodule : i2c_master_controller_tb
`default_nettype wire
